/* core/wsc_pkg.sv */
package wsc_pkg;

	// register addresses on the serial configuration port
	localparam logic [6:0] WSC_ADDR_WD = 7'h03;
	localparam logic [6:0] WSC_ADDR_BUS = 7'h04;
	localparam logic [6:0] WSC_ADDR_IWC = 7'h06;
	localparam logic [6:0] WSC_ADDR_EWC = 7'h07;

	// frame layout, first bit on the line is bit 0
	localparam logic [4:0] WSC_FRAME_BITS = 5'h10;
	localparam logic [4:0] WSC_HEAD_BITS = 5'h08;
	localparam logic [4:0] WSC_CNT_MAX = 5'h1f;
	localparam int WSC_RW_POS = 7;

	// values after power-on or soft reset
	localparam logic [7:0] WSC_IWC_RST = 8'h00;
	localparam logic [7:0] WSC_EWC_RST = 8'h07;
	localparam logic [7:0] WSC_BUS_RST = 8'h20;
	localparam logic [7:0] WSC_WD_RST = 8'h14;

	// implemented bits, everything else reads zero and ignores writes
	localparam logic [7:0] WSC_IWC_MASK = 8'hc4;
	localparam logic [7:0] WSC_EWC_MASK = 8'ha7;
	localparam logic [7:0] WSC_BUS_MASK = 8'hfb;
	localparam logic [7:0] WSC_WD_MASK = 8'h40;

	// restart and fail-safe forcing: keep-mask and forced value
	localparam logic [7:0] WSC_EWC_RESTART_KEEP = 8'ha7;
	localparam logic [7:0] WSC_EWC_FS_KEEP = 8'ha0;
	localparam logic [7:0] WSC_EWC_FS_VAL = 8'h07;
	localparam logic [7:0] WSC_BUS_FS_KEEP = 8'he0;
	localparam logic [7:0] WSC_BUS_FS_VAL = 8'h09;

	// field positions
	localparam int WSC_IWC_T2_POS = 7;
	localparam int WSC_IWC_T1_POS = 6;
	localparam int WSC_IWC_WDHI_POS = 2;
	localparam int WSC_EWC_GLB_POS = 7;
	localparam int WSC_EWC_MEAS_POS = 5;
	localparam int WSC_EWC_WK3_POS = 2;
	localparam int WSC_EWC_WK2_POS = 1;
	localparam int WSC_EWC_WK1_POS = 0;
	localparam int WSC_WD_LO_POS = 6;
	localparam int WSC_BUS_LIN_LSB = 3;
	localparam int WSC_BUS_CAN_LSB = 0;

	// transceiver mode field encoding
	localparam logic [1:0] WSC_MODE_WAKE = 2'h1;

	typedef struct packed {
		logic second_timer_wake_enable;
		logic first_timer_wake_enable;
		logic wake_input_three_enable;
		logic wake_input_two_enable;
		logic wake_input_one_enable;
		logic measure_active;
	} wsc_wake_en_t;

	typedef struct packed {
		logic [1:0] timer_hit;
		logic [2:0] wake_input_hit;
	} wsc_wake_hit_t;

endpackage

/* core/wsc_regs.sv */
`timescale 1ns/10ps
// Function
// - bit 7 internal register enables second timer wake; cleared means no wake.
// - bit 6 internal register enables first timer wake; cleared keeps it off.
// - bit 2 internal is watchdog stop-disable high bit; device may update it.
// - low watchdog stop-disable bit sits at watchdog control bit 6, same encoding.
// - reserved bits of both wake registers always read zero.
// - external bit 7 picks interrupt policy: wake only, or every status bit.
// - external bit 5 selects measurement; then inputs one and two enables ignored.
// - measurement runs in normal mode; software ignores input one/two level bits.
// - external bits 2,1,0 enable wake inputs three, two, one.
// - power-on or soft reset loads internal register with zero.
// - power-on or soft reset loads external register with 0000 0111.
// - restart entry clears external bits 6,4,3 and keeps the rest.
// - fail-safe entry forces external x0x0 0111 and bus control xxx0 1001.
// - transceiver mode value 01 means wake capable only.
module wsc_regs
	import wsc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	input wire logic soft_reset,
	input wire logic restart_entry,
	input wire logic failsafe_entry,
	input wire logic normal_mode,
	input wire logic wd_stop_hi_set,
	input wire logic wd_stop_hi_val,
	input wire logic wd_stop_lo_set,
	input wire logic wd_stop_lo_val,
	input wire wsc_wake_hit_t wake_hit,
	input wire logic status_event,
	output wsc_wake_en_t wake_en,
	output logic int_global,
	output logic [1:0] wd_stop_disable,
	output logic can_wake_capable,
	output logic lin_wake_capable,
	output logic wake_detect,
	output logic int_req
);

	logic cs_n_s;
	logic sclk_s;
	logic sdi_s;
	logic cs_n_d;
	logic sclk_d;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;
	logic [4:0] bit_cnt_r;
	logic [15:0] rx_r;
	logic [7:0] tx_r;
	logic [7:0] iwc_r;
	logic [7:0] ewc_r;
	logic [7:0] bus_r;
	logic [7:0] wd_r;
	logic [7:0] iwc_nxt;
	logic [7:0] wd_nxt;
	logic [7:0] rd_data;
	logic [7:0] status_byte;
	logic wr_commit;
	logic [6:0] wr_addr;
	logic [7:0] wr_data;
	logic wr_iwc;
	logic wr_ewc;
	logic wr_bus;
	logic wr_wd;
	logic meas_sel;
	logic [4:0] wake_gate;
	logic wake_any;

	// pins come from the host's domain, so sclk must run well below clk/4
	wsc_sync #(.INIT(1'b1)) u_sync_cs (
		.clk(clk),
		.rst(rst),
		.din(spi_cs_n),
		.dout(cs_n_s)
	);

	wsc_sync #(.INIT(1'b0)) u_sync_sclk (
		.clk(clk),
		.rst(rst),
		.din(spi_sclk),
		.dout(sclk_s)
	);

	wsc_sync #(.INIT(1'b0)) u_sync_sdi (
		.clk(clk),
		.rst(rst),
		.din(spi_sdi),
		.dout(sdi_s)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cs_n_d <= 1'b1;
			sclk_d <= 1'b0;
		end else begin
			cs_n_d <= cs_n_s;
			sclk_d <= sclk_s;
		end
	end

	assign sclk_rise = sclk_s & ~sclk_d & ~cs_n_s;
	assign sclk_fall = ~sclk_s & sclk_d & ~cs_n_s;
	assign cs_fall = ~cs_n_s & cs_n_d;
	assign cs_rise = cs_n_s & ~cs_n_d;

	// bit counter saturates so an overlong frame can never look like sixteen
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bit_cnt_r <= '0;
		end else if (cs_fall) begin
			bit_cnt_r <= '0;
		end else if (sclk_rise && bit_cnt_r != WSC_CNT_MAX) begin
			bit_cnt_r <= bit_cnt_r + 5'h01;
		end
	end

	// first bit on the line ends up in bit 0
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_r <= '0;
		end else if (sclk_rise) begin
			rx_r <= {sdi_s, rx_r[15:1]};
		end
	end

	always_comb begin
		rd_data = 8'h00;
		unique case (rx_r[14:8])
			WSC_ADDR_WD: rd_data = wd_r & WSC_WD_MASK;
			WSC_ADDR_BUS: rd_data = bus_r & WSC_BUS_MASK;
			WSC_ADDR_IWC: rd_data = iwc_r & WSC_IWC_MASK;
			WSC_ADDR_EWC: rd_data = ewc_r & WSC_EWC_MASK;
			default: rd_data = 8'h00;
		endcase
	end

	assign status_byte = {2'h0, wake_en};

	// status byte goes out first, addressed register after the head bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_r <= '0;
			spi_sdo <= 1'b0;
		end else if (cs_fall) begin
			tx_r <= {1'b0, status_byte[7:1]};
			spi_sdo <= status_byte[0];
		end else if (sclk_fall) begin
			if (bit_cnt_r == WSC_HEAD_BITS) begin
				tx_r <= {1'b0, rd_data[7:1]};
				spi_sdo <= rd_data[0];
			end else begin
				tx_r <= {1'b0, tx_r[7:1]};
				spi_sdo <= tx_r[0];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			spi_sdo_oe <= 1'b0;
		end else begin
			spi_sdo_oe <= ~cs_n_s;
		end
	end

	// a write only lands on a clean sixteen-bit frame
	assign wr_commit = cs_rise && bit_cnt_r == WSC_FRAME_BITS && rx_r[WSC_RW_POS];
	assign wr_addr = rx_r[6:0];
	assign wr_data = rx_r[15:8];
	assign wr_iwc = wr_commit && wr_addr == WSC_ADDR_IWC;
	assign wr_ewc = wr_commit && wr_addr == WSC_ADDR_EWC;
	assign wr_bus = wr_commit && wr_addr == WSC_ADDR_BUS;
	assign wr_wd = wr_commit && wr_addr == WSC_ADDR_WD;

	// hardware update lands after the host write so it wins a collision
	always_comb begin
		iwc_nxt = iwc_r;
		if (wr_iwc) begin
			iwc_nxt = wr_data & WSC_IWC_MASK;
		end
		if (wd_stop_hi_set) begin
			iwc_nxt[WSC_IWC_WDHI_POS] = wd_stop_hi_val;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			iwc_r <= WSC_IWC_RST;
		end else if (soft_reset) begin
			iwc_r <= WSC_IWC_RST;
		end else begin
			iwc_r <= iwc_nxt;
		end
	end

	// fail-safe outranks restart, both outrank a host write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ewc_r <= WSC_EWC_RST;
		end else if (soft_reset) begin
			ewc_r <= WSC_EWC_RST;
		end else if (failsafe_entry) begin
			ewc_r <= (ewc_r & WSC_EWC_FS_KEEP) | WSC_EWC_FS_VAL;
		end else if (restart_entry) begin
			ewc_r <= ewc_r & WSC_EWC_RESTART_KEEP;
		end else if (wr_ewc) begin
			ewc_r <= wr_data & WSC_EWC_MASK;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_r <= WSC_BUS_RST;
		end else if (soft_reset) begin
			bus_r <= WSC_BUS_RST;
		end else if (failsafe_entry) begin
			bus_r <= (bus_r & WSC_BUS_FS_KEEP) | WSC_BUS_FS_VAL;
		end else if (wr_bus) begin
			bus_r <= wr_data & WSC_BUS_MASK;
		end
	end

	always_comb begin
		wd_nxt = wd_r;
		if (wr_wd) begin
			wd_nxt = wr_data & WSC_WD_MASK;
		end
		if (wd_stop_lo_set) begin
			wd_nxt[WSC_WD_LO_POS] = wd_stop_lo_val;
		end
	end

	// only the stop-mode bit lives here, the rest of watchdog control is elsewhere
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wd_r <= WSC_WD_RST & WSC_WD_MASK;
		end else if (soft_reset) begin
			wd_r <= WSC_WD_RST & WSC_WD_MASK;
		end else begin
			wd_r <= wd_nxt;
		end
	end

	assign meas_sel = ewc_r[WSC_EWC_MEAS_POS];

	// gated enables: timer2, timer1, wk3, wk2, wk1
	assign wake_gate = {
		iwc_r[WSC_IWC_T2_POS],
		iwc_r[WSC_IWC_T1_POS],
		ewc_r[WSC_EWC_WK3_POS],
		ewc_r[WSC_EWC_WK2_POS] & ~meas_sel,
		ewc_r[WSC_EWC_WK1_POS] & ~meas_sel
	};

	assign wake_any = |(wake_gate & {wake_hit.timer_hit, wake_hit.wake_input_hit});

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wake_en <= '0;
		end else begin
			wake_en.second_timer_wake_enable <= wake_gate[4];
			wake_en.first_timer_wake_enable <= wake_gate[3];
			wake_en.wake_input_three_enable <= wake_gate[2];
			wake_en.wake_input_two_enable <= wake_gate[1];
			wake_en.wake_input_one_enable <= wake_gate[0];
			wake_en.measure_active <= meas_sel & normal_mode;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wd_stop_disable <= 2'h0;
		end else begin
			wd_stop_disable <= {iwc_r[WSC_IWC_WDHI_POS], wd_r[WSC_WD_LO_POS]};
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			can_wake_capable <= 1'b0;
			lin_wake_capable <= 1'b0;
		end else begin
			can_wake_capable <= bus_r[WSC_BUS_CAN_LSB +: 2] == WSC_MODE_WAKE;
			lin_wake_capable <= bus_r[WSC_BUS_LIN_LSB +: 2] == WSC_MODE_WAKE;
		end
	end

	// interrupt follows one cycle after the event that causes it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			int_global <= 1'b0;
			wake_detect <= 1'b0;
			int_req <= 1'b0;
		end else begin
			int_global <= ewc_r[WSC_EWC_GLB_POS];
			wake_detect <= wake_any;
			int_req <= wake_any | (ewc_r[WSC_EWC_GLB_POS] & status_event);
		end
	end

endmodule

/* core/wsc_sync.sv */
`timescale 1ns/10ps
// two-stage synchroniser, only the second stage is visible
module wsc_sync #(
	parameter logic INIT = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic din,
	output logic dout
);

	logic meta_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r <= INIT;
			dout <= INIT;
		end else begin
			meta_r <= din;
			dout <= meta_r;
		end
	end

endmodule

/* test/test_wake_source_control_regs.sv */
`timescale 1ns/10ps
module test_wake_source_control_regs;
	import wsc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] ev = 5'h00;
	logic hw_val = 1'b1;
	logic normal_mode = 1'b1;
	logic status_event = 1'b0;
	wsc_wake_hit_t wake_hit = 5'h00;
	logic spi_cs_n, spi_sclk, spi_sdi, spi_sdo, int_global, wake_detect, int_req, can_wk, lin_wk;
	wsc_wake_en_t wake_en;
	logic [1:0] wd_dis;
	logic sdo_oe, sdo_line;
	logic [15:0] rx;
	int err_count = 0;
	int compares = 0;
	always #5 clk = ~clk;
	// host sees its pull-up whenever the block does not drive the line
	assign sdo_line = sdo_oe ? spi_sdo : 1'b1;
	wsc_host host(.clk(clk), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(sdo_line));
	wsc_regs uut(.clk(clk), .rst(rst), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi),
		.spi_sdo(spi_sdo), .spi_sdo_oe(sdo_oe), .soft_reset(ev[0]), .restart_entry(ev[1]), .failsafe_entry(ev[2]),
		.normal_mode(normal_mode), .wd_stop_hi_set(ev[3]), .wd_stop_hi_val(hw_val), .wd_stop_lo_set(ev[4]),
		.wd_stop_lo_val(hw_val), .wake_hit(wake_hit), .status_event(status_event), .wake_en(wake_en),
		.int_global(int_global), .wd_stop_disable(wd_dis), .can_wake_capable(can_wk),
		.lin_wake_capable(lin_wk), .wake_detect(wake_detect), .int_req(int_req));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host.xfer({1'b1, a}, d, 0, rx);
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		host.xfer({1'b0, a}, 8'h5a, 0, rx);
		chk(rx[15:8], e);
	endtask
	task automatic pulse(input int b);
		@(posedge clk) #1 ev[b] = 1'b1;
		@(posedge clk) #1 ev[b] = 1'b0;
		repeat (3) @(posedge clk);
	endtask
	// one source at a time, held long enough to pass any input sync
	task automatic hit(input int b, input logic e);
		@(posedge clk) #1 wake_hit = 5'h01 << b;
		repeat (4) @(posedge clk);
		#1 chk({6'h00, wake_detect, int_req}, {6'h00, e, e});
		wake_hit = 5'h00;
		repeat (4) @(posedge clk);
	endtask
	task wrap_up;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// run needs roughly 46 us; about five times that before giving up
	initial begin
		#250000;
		err_count++;
		wrap_up;
	end
	initial begin
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		repeat (4) @(posedge clk);
		rd(WSC_ADDR_IWC, 8'h00);
		rd(WSC_ADDR_EWC, 8'h07);
		chk({2'h0, wake_en}, 8'h0e);
		chk({7'h00, sdo_oe}, 8'h00);
		wr(WSC_ADDR_IWC, 8'hff);
		rd(WSC_ADDR_IWC, 8'hc4);
		wr(WSC_ADDR_EWC, 8'hff);
		rd(WSC_ADDR_EWC, 8'ha7);
		chk({2'h0, wake_en}, 8'h39);
		pulse(1);
		rd(WSC_ADDR_EWC, 8'ha7);
		wr(WSC_ADDR_BUS, 8'hff);
		wr(WSC_ADDR_EWC, 8'h20);
		pulse(2);
		rd(WSC_ADDR_EWC, 8'h27);
		rd(WSC_ADDR_BUS, 8'he9);
		chk({6'h00, can_wk, lin_wk}, 8'h03);
		normal_mode = 1'b0;
		repeat (3) @(posedge clk);
		#1 chk({2'h0, wake_en}, 8'h38);
		for (int b = 0; b < 5; b++) hit(b, b >= 2);
		for (int m = 0; m < 4; m++) begin
			wr(WSC_ADDR_BUS, {3'h0, m[1:0], 1'b0, m[1:0]});
			chk({6'h00, can_wk, lin_wk}, (m == 1) ? 8'h03 : 8'h00);
		end
		wr(WSC_ADDR_EWC, 8'h07);
		wr(WSC_ADDR_IWC, 8'h00);
		for (int b = 0; b < 5; b++) hit(b, b < 3);
		wr(WSC_ADDR_EWC, 8'h00);
		wr(WSC_ADDR_IWC, 8'hc0);
		for (int b = 0; b < 5; b++) hit(b, b >= 3);
		#1 status_event = 1'b1;
		repeat (4) @(posedge clk);
		#1 chk({6'h00, int_global, int_req}, 8'h00);
		wr(WSC_ADDR_EWC, 8'h80);
		chk({6'h00, int_global, int_req}, 8'h03);
		status_event = 1'b0;
		pulse(3);
		pulse(4);
		#1 chk({6'h00, wd_dis}, 8'h03);
		rd(WSC_ADDR_WD, 8'h40);
		rd(WSC_ADDR_IWC, 8'hc4);
		hw_val = 1'b0;
		pulse(3);
		#1 chk({6'h00, wd_dis}, 8'h01);
		pulse(4);
		#1 chk({6'h00, wd_dis}, 8'h00);
		// slow host against an unmapped place
		host.xfer(8'h10, 8'h5a, 3, rx);
		chk(rx[15:8], 8'h00);
		pulse(0);
		rd(WSC_ADDR_EWC, 8'h07);
		rd(WSC_ADDR_IWC, 8'h00);
		wrap_up;
	end
endmodule

/* test/wsc_host.sv */
`timescale 1ns/10ps
module wsc_host (
	input wire logic clk,
	output logic spi_cs_n,
	output logic spi_sclk,
	output logic spi_sdi,
	input wire logic spi_sdo
);
	initial begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		spi_sdi = 1'b0;
	end
	// mode 0, lsb first; slow stretches each phase to mimic a lazy host
	task automatic xfer(input logic [7:0] head, input logic [7:0] d, input int slow, output logic [15:0] rx);
		logic [15:0] fr;
		fr = {d, head};
		@(posedge clk) #1 spi_cs_n = 1'b0;
		spi_sdi = fr[0];
		for (int i = 0; i < 16; i++) begin
			repeat (5 + slow) @(posedge clk);
			#1 spi_sclk = 1'b1;
			rx[i] = spi_sdo;
			repeat (5 + slow) @(posedge clk);
			#1 spi_sclk = 1'b0;
			// released data line shows no stale value
			spi_sdi = (i < 15) ? fr[i+1] : ~fr[15];
		end
		repeat (5) @(posedge clk);
		#1 spi_cs_n = 1'b1;
		repeat (7) @(posedge clk);
		#1 spi_sdi = ~spi_sdi;
	endtask
endmodule

/* test/wsc_regs_asserts.sv */
`timescale 1ns/10ps
module wsc_regs_chk
	import wsc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic soft_reset,
	input wire logic restart_entry,
	input wire logic failsafe_entry,
	input wire logic wd_stop_hi_set,
	input wire logic wd_stop_hi_val,
	input wire wsc_wake_hit_t wake_hit,
	input wire logic status_event,
	input wire wsc_wake_en_t wake_en,
	input wire logic int_global,
	input wire logic [1:0] wd_stop_disable,
	input wire logic can_wake_capable,
	input wire logic lin_wake_capable,
	input wire logic wake_detect,
	input wire logic int_req
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// policy bit must be seen on two samples, the output copy lags the register
	sequence s_glob_evt;
		int_global && status_event ##1 int_global;
	endsequence
	sequence s_quiet;
		(wake_hit == 5'h00) [*3] ##0 !int_global ##1 !int_global;
	endsequence
	a_glob_any_evt: assert property (s_glob_evt |-> int_req)
		else $error("status event did not raise int_req");
	a_wake_only_int: assert property (s_quiet |-> !int_req)
		else $error("int_req without wake");
	a_timer2_wake: assert property ((wake_hit.timer_hit[1] && wake_en.second_timer_wake_enable) [*2] |-> ##[1:4] wake_detect)
		else $error("timer2 wake missed");
	a_input3_wake: assert property ((wake_hit.wake_input_hit[2] && wake_en.wake_input_three_enable) [*2] |-> ##[1:4] wake_detect)
		else $error("input3 wake missed");
	a_meas_gates_en: assert property (wake_en.measure_active |-> !wake_en.wake_input_one_enable && !wake_en.wake_input_two_enable)
		else $error("measure left wk1/wk2 enabled");
	a_soft_rst_vals: assert property (soft_reset |-> ##2 (wake_en == 6'h0e && !int_global && wd_stop_disable == 2'h0))
		else $error("soft reset values wrong");
	a_failsafe_wake: assert property (failsafe_entry && !soft_reset |-> ##2 (wake_en.wake_input_three_enable && can_wake_capable && lin_wake_capable))
		else $error("fail-safe forcing wrong");
	a_restart_keeps: assert property (restart_entry && !soft_reset && !failsafe_entry |=> ##1 ($stable(int_global) && $stable(wake_en[5:1])))
		else $error("restart changed kept bits");
	a_wd_hi_update: assert property (wd_stop_hi_set && !soft_reset |-> ##2 wd_stop_disable[1] == $past(wd_stop_hi_val, 2))
		else $error("hw update of stop bit lost");
endmodule
bind wsc_regs wsc_regs_chk chk(.clk, .rst, .soft_reset, .restart_entry, .failsafe_entry, .wd_stop_hi_set, .wd_stop_hi_val,
	.wake_hit, .status_event, .wake_en, .int_global, .wd_stop_disable, .can_wake_capable, .lin_wake_capable,
	.wake_detect, .int_req);
